//--- design/lpc_power_ctrl.sv
// Power-mode controller: applies per-mode clock and oscillator gating
`timescale 1ns/1ns
module lpc_power_ctrl #(
  parameter int unsigned WAKE_CYCLES = lpc_pkg::WAKE_CYC,
  parameter int unsigned SETTLE_CYCLES = lpc_pkg::OSC_SETTLE_CYC
) (
  input  wire logic        core_clk_i,       // 10 MHz core clock
  input  wire logic        nrst_i,           // Async active-low reset
  input  wire logic [2:0]  mode_sel_i,       // Requested mode from processor
  input  wire logic        irq_pend_i,       // Interrupt request level, async
  input  wire logic [3:0]  irq_vec_i,        // Vector number of request
  input  wire logic        dto_used_i,       // Tuned oscillator sources a clock
  input  wire logic        aux_src_hf_i,     // Auxiliary from fast crystal
  output logic             cpu_run_o,        // Processor may execute
  output logic             main_clk_en_o,    // Main (processor) clock gate
  output logic             peripheral_subclock_en_o, // Peripheral clock gate
  output logic             aux_clk_en_o,     // Auxiliary clock gate
  output logic             aux_src_hf_o,     // Auxiliary source select
  output logic             dto_dcgen_en_o,   // Oscillator dc-generator power
  output logic             xtal_en_o,        // Crystal oscillator run
  output logic [2:0]       mode_o,           // Mode now in force
  output logic             waking_o,         // Wake sequence in progress
  output logic             wake_late_o,      // Sticky: wake overran bound
  output logic [15:0]      vec_addr_o,       // Vector address to fetch
  output logic             vec_valid_o       // Vector address is valid
);

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic rst_s1_q;                            // Reset release stage one
  logic rst_n;                               // Synchronised reset
  logic irq_s1_q;                            // Interrupt sync stage one
  logic irq_s2_q;                            // Interrupt sync stage two

  // Reset deasserts through two flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Interrupt is asynchronous to this block, two flops first
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_pend_i;
      irq_s2_q <= irq_s1_q;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  lpc_pkg::lpc_mode_e req_mode;              // Decoded software request

  // Unknown codes fall back to active, never a deeper sleep
  always_comb begin
    case (mode_sel_i)
      lpc_pkg::SEL_ACTIVE: req_mode = lpc_pkg::LPC_ACTIVE_RUN_MODE;
      lpc_pkg::SEL_LVL0:   req_mode = lpc_pkg::LPC_SLEEP_LEVEL_ZERO;
      lpc_pkg::SEL_LVL1:   req_mode = lpc_pkg::LPC_SLEEP_LEVEL_ONE;
      lpc_pkg::SEL_LVL2:   req_mode = lpc_pkg::LPC_SLEEP_LEVEL_TWO;
      lpc_pkg::SEL_LVL3:   req_mode = lpc_pkg::LPC_SLEEP_LEVEL_THREE;
      lpc_pkg::SEL_LVL4:   req_mode = lpc_pkg::LPC_SLEEP_LEVEL_FOUR;
      default:             req_mode = lpc_pkg::LPC_ACTIVE_RUN_MODE;
    endcase
  end

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } lpc_state_e;

  lpc_state_e          state_q;              // Controller state
  lpc_state_e          state_d;
  lpc_pkg::lpc_mode_e  mode_q;               // Mode in force
  lpc_pkg::lpc_mode_e  mode_d;
  logic                dto_act_q;            // Oscillator used while active
  logic                dto_act_d;
  logic [15:0]         wcnt_q;               // Wake cycle counter
  logic [15:0]         wcnt_d;
  logic                late_q;               // Sticky overrun flag
  logic                late_d;
  logic                settled;              // Oscillator settle reached

  assign settled = (32'(wcnt_q) >= SETTLE_CYCLES);

  // Next state: sleep on request, wake on interrupt
  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    dto_act_d = dto_act_q;
    wcnt_d    = wcnt_q;
    late_d    = late_q;
    case (state_q)
      ST_RUN: begin
        dto_act_d = dto_used_i;              // Sampled while active
        if (req_mode != lpc_pkg::LPC_ACTIVE_RUN_MODE && !irq_s2_q) begin
          mode_d  = req_mode;
          state_d = ST_SLEEP;
        end else begin
          mode_d  = lpc_pkg::LPC_ACTIVE_RUN_MODE;
        end
      end
      ST_SLEEP: begin
        // Interrupt wakes from any level; processor clears select bits
        if (irq_s2_q || req_mode == lpc_pkg::LPC_ACTIVE_RUN_MODE) begin
          state_d = ST_WAKE;
          wcnt_d  = 16'h0000;
        end else begin
          mode_d  = req_mode;
        end
      end
      ST_WAKE: begin
        // Oscillator restarts; active mode inside bound
        wcnt_d = wcnt_q + 16'h0001;
        if (settled || 32'(wcnt_q) + 32'd1 >= WAKE_CYCLES) begin
          if (!settled) begin
            late_d = 1'b1;                   // Forced on time, flagged
          end
          mode_d  = lpc_pkg::LPC_ACTIVE_RUN_MODE;
          state_d = ST_RUN;                  // Return re-enters sleep
        end
      end
      default: begin
        state_d = ST_RUN;
        mode_d  = lpc_pkg::LPC_ACTIVE_RUN_MODE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_RUN;
      mode_q    <= lpc_pkg::LPC_ACTIVE_RUN_MODE;
      dto_act_q <= 1'b1;
      wcnt_q    <= 16'h0000;
      late_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      dto_act_q <= dto_act_d;
      wcnt_q    <= wcnt_d;
      late_q    <= late_d;
    end
  end

  // ****************************************************************
  // Gating table
  // ****************************************************************
  logic [5:0] gate_d;                        // Next gate vector
  logic [5:0] gate_q;                        // Registered gates
  logic       aux_hf_q;                      // Registered aux source
  logic       wake_q;                        // Registered wake flag
  logic [2:0] mode_out_q;                    // Registered mode code

  // Wake phase restarts oscillator but keeps processor halted
  always_comb begin
    gate_d = lpc_pkg::GATE_RESET;
    case (mode_q)
      lpc_pkg::LPC_ACTIVE_RUN_MODE: gate_d = lpc_pkg::GATE_RESET;
      lpc_pkg::LPC_SLEEP_LEVEL_ZERO: begin
        gate_d[lpc_pkg::GB_CPU]  = 1'b0;
        gate_d[lpc_pkg::GB_MAIN] = 1'b0;
      end
      lpc_pkg::LPC_SLEEP_LEVEL_ONE: begin
        gate_d[lpc_pkg::GB_CPU]   = 1'b0;
        gate_d[lpc_pkg::GB_MAIN]  = 1'b0;
        gate_d[lpc_pkg::GB_DCGEN] = dto_act_q;
      end
      lpc_pkg::LPC_SLEEP_LEVEL_TWO: begin
        gate_d[lpc_pkg::GB_CPU]  = 1'b0;
        gate_d[lpc_pkg::GB_MAIN] = 1'b0;
        gate_d[lpc_pkg::GB_SUB]  = 1'b0;
      end
      lpc_pkg::LPC_SLEEP_LEVEL_THREE: begin
        gate_d[lpc_pkg::GB_CPU]   = 1'b0;
        gate_d[lpc_pkg::GB_MAIN]  = 1'b0;
        gate_d[lpc_pkg::GB_SUB]   = 1'b0;
        gate_d[lpc_pkg::GB_DCGEN] = 1'b0;
      end
      lpc_pkg::LPC_SLEEP_LEVEL_FOUR: gate_d = 6'h00;
      default: gate_d = lpc_pkg::GATE_RESET;
    endcase
    if (state_q == ST_WAKE) begin
      // Oscillators back on, clocks held until settled
      // Order xtal, dc-gen, aux, sub, main, cpu: sources and aux run, rest off
      gate_d = {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    end
  end

  // Output registers
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_q     <= lpc_pkg::GATE_RESET;
      aux_hf_q   <= 1'b0;
      wake_q     <= 1'b0;
      mode_out_q <= lpc_pkg::SEL_ACTIVE;
    end else begin
      gate_q     <= gate_d;
      aux_hf_q   <= aux_src_hf_i;
      wake_q     <= (state_q == ST_WAKE);
      mode_out_q <= 3'(mode_q);
    end
  end

  // ****************************************************************
  // Vector fetch address
  // ****************************************************************
  logic vec_rd;                              // Lookup on wake entry or on interrupt while running

  assign vec_rd = (state_q == ST_SLEEP && state_d == ST_WAKE)
               || (state_q == ST_RUN && irq_s2_q);

  lpc_vec_rom lpc_vec_rom_i (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .rd_i    (vec_rd),
    .idx_i   (irq_vec_i),
    .addr_o  (vec_addr_o),
    .ok_o    (vec_valid_o)
  );

  assign cpu_run_o                = gate_q[lpc_pkg::GB_CPU];
  assign main_clk_en_o            = gate_q[lpc_pkg::GB_MAIN];
  assign peripheral_subclock_en_o = gate_q[lpc_pkg::GB_SUB];
  assign aux_clk_en_o             = gate_q[lpc_pkg::GB_AUX];
  assign dto_dcgen_en_o           = gate_q[lpc_pkg::GB_DCGEN];
  assign xtal_en_o                = gate_q[lpc_pkg::GB_XTAL];
  assign aux_src_hf_o             = aux_hf_q;
  assign waking_o                 = wake_q;
  assign wake_late_o              = late_q;
  assign mode_o                   = mode_out_q;

endmodule

//--- design/lpc_vec_rom.sv
// Vector-address generator: word address of an interrupt or reset vector
`timescale 1ns/1ns
module lpc_vec_rom #(
  parameter int unsigned NUM_VEC = lpc_pkg::VEC_COUNT
) (
  input  wire logic        clk_i,            // Core clock
  input  wire logic        rst_n_i,          // Synchronised reset
  input  wire logic        rd_i,             // Lookup request
  input  wire logic [3:0]  idx_i,            // Vector number, 15 is reset
  output logic      [15:0] addr_o,           // Registered vector address
  output logic             ok_o              // Address inside vector range
);

  logic [15:0] addr_d;                       // Next address
  logic [15:0] addr_q;                       // Held address
  logic        ok_d;                         // Next range flag
  logic        ok_q;                         // Held range flag

  // ****************************************************************
  // Address computation: base plus two bytes per vector
  // ****************************************************************
  always_comb begin
    addr_d = addr_q;
    ok_d   = ok_q;
    if (rd_i) begin
      addr_d = lpc_pkg::VEC_BASE + {11'h000, idx_i, 1'b0};
      ok_d   = (32'(idx_i) < NUM_VEC) && (addr_d <= lpc_pkg::VEC_TOP);
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= lpc_pkg::VEC_RESET_ADDR;
      ok_q   <= 1'b1;
    end else begin
      addr_q <= addr_d;
      ok_q   <= ok_d;
    end
  end

  assign addr_o = addr_q;
  assign ok_o   = ok_q;

endmodule

//--- inc/lpc_pkg.sv
// Package: modes, gating table fields, timing and vector constants for the power controller
package lpc_pkg;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    LPC_ACTIVE_RUN_MODE,
    LPC_SLEEP_LEVEL_ZERO,
    LPC_SLEEP_LEVEL_ONE,
    LPC_SLEEP_LEVEL_TWO,
    LPC_SLEEP_LEVEL_THREE,
    LPC_SLEEP_LEVEL_FOUR
  } lpc_mode_e;

  // ****************************************************************
  // Mode-select field from the processor
  // ****************************************************************
  localparam int unsigned SEL_W            = 3;
  localparam logic [2:0]  SEL_ACTIVE       = 3'h0;
  localparam logic [2:0]  SEL_LVL0         = 3'h1;
  localparam logic [2:0]  SEL_LVL1         = 3'h2;
  localparam logic [2:0]  SEL_LVL2         = 3'h3;
  localparam logic [2:0]  SEL_LVL3         = 3'h4;
  localparam logic [2:0]  SEL_LVL4         = 3'h5;

  // ****************************************************************
  // Gate vector bit positions (1 = enabled)
  // ****************************************************************
  localparam int unsigned GATE_W           = 6;
  localparam int unsigned GB_CPU           = 0;
  localparam int unsigned GB_MAIN          = 1;
  localparam int unsigned GB_SUB           = 2;
  localparam int unsigned GB_AUX           = 3;
  localparam int unsigned GB_DCGEN         = 4;
  localparam int unsigned GB_XTAL          = 5;
  localparam logic [5:0]  GATE_RESET       = 6'h3F;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned WAKE_MAX_NS      = 6000;
  // Longest time rounds down
  localparam int unsigned WAKE_CYC         = WAKE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned OSC_SETTLE_CYC   = 8;
  localparam int unsigned AUX_XTAL_HZ      = 32768;

  // ****************************************************************
  // Vector table
  // ****************************************************************
  localparam logic [15:0] VEC_BASE         = 16'hFFE0;
  localparam logic [15:0] VEC_TOP          = 16'hFFFF;
  localparam logic [15:0] VEC_RESET_ADDR   = 16'hFFFE;
  localparam int unsigned VEC_COUNT        = 16;

endpackage

//--- verification/lpc_cpu_model.sv
// Processor model: mode-select bits, interrupt entry and return
`timescale 1ns/1ns
module lpc_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       cpu_run_i,   // Device lets the processor execute
  input  wire logic [2:0] sw_mode_i,   // Mode the main program asks for
  input  wire logic       raise_i,     // Peripheral raises a request
  input  wire logic [3:0] vec_i,       // Its vector number
  output logic      [2:0] mode_sel_o,  // Mode-select bits
  output logic            irq_pend_o,  // Pending request level
  output logic      [3:0] irq_vec_o,   // Vector of pending request
  output int              served_o     // Handlers run so far
);
  logic in_isr_q;   // Handler running
  int   isr_cnt_q;  // Handler length counter
  initial begin
    in_isr_q = 1'b0;
    isr_cnt_q = 0;
    irq_pend_o = 1'b0;
    irq_vec_o = 4'h0;
    served_o = 0;
  end
  // Entry clears the bits, return restores the saved ones
  assign mode_sel_o = in_isr_q ? 3'h0 : sw_mode_i;
  // Request, handler and return
  always @(posedge clk_i) begin
    if (raise_i) begin
      irq_pend_o <= 1'b1;
      irq_vec_o <= vec_i;
    end else if (!irq_pend_o) begin
      irq_vec_o <= ~irq_vec_o; // Idle vector toggles, never a stale value
    end
    if (!in_isr_q && irq_pend_o && cpu_run_i) begin
      in_isr_q <= 1'b1;
      isr_cnt_q <= 0;
    end
    if (in_isr_q) begin
      isr_cnt_q <= isr_cnt_q + 1;
      if (isr_cnt_q == 3) irq_pend_o <= 1'b0;  // Handler clears its flag
      if (isr_cnt_q == 4) begin
        in_isr_q <= 1'b0;
        served_o <= served_o + 1;
      end
    end
  end
endmodule

//--- verification/lpc_power_ctrl_checker.sv
// Checker: gating relations at the power controller's ports
`timescale 1ns/1ns
module lpc_power_ctrl_checker (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        irq_pend_i,
  input  wire logic        cpu_run_o,
  input  wire logic        main_clk_en_o,
  input  wire logic        peripheral_subclock_en_o,
  input  wire logic        aux_clk_en_o,
  input  wire logic        dto_dcgen_en_o,
  input  wire logic        xtal_en_o,
  input  wire logic        waking_o,
  input  wire logic        wake_late_o,
  input  wire logic [15:0] vec_addr_o,
  input  wire logic        vec_valid_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ****************************************************************
  // Wake sequence steps
  // ****************************************************************
  sequence wake_start_s;
    $rose(waking_o);
  endsequence
  sequence wake_gates_s;
    !cpu_run_o && aux_clk_en_o && dto_dcgen_en_o && xtal_en_o;
  endsequence
  run_all_on_a: assert property (cpu_run_o |-> main_clk_en_o && peripheral_subclock_en_o
    && aux_clk_en_o && dto_dcgen_en_o && xtal_en_o) else $error("clock gated while running");
  cpu_main_tie_a: assert property (cpu_run_o == main_clk_en_o)
    else $error("processor run and main clock disagree");
  sub_over_main_a: assert property (!peripheral_subclock_en_o |-> !main_clk_en_o)
    else $error("main clock on with sub clock off");
  aux_off_all_a: assert property (!aux_clk_en_o |-> !xtal_en_o && !dto_dcgen_en_o
    && !peripheral_subclock_en_o) else $error("aux off but other sources on");
  irq_wakes_a: assert property ($rose(irq_pend_i) && !cpu_run_o && !waking_o
    |-> ##[1:6] waking_o) else $error("interrupt did not wake");
  wake_gates_a: assert property (wake_start_s |-> wake_gates_s)
    else $error("wrong gating in wake phase");
  wake_bound_a: assert property (wake_start_s |-> ##[1:60] !waking_o)
    else $error("wake phase too long");
  wake_to_run_a: assert property ($fell(waking_o) |-> ##[0:1] cpu_run_o)
    else $error("wake end without run");
  never_late_a: assert property (!wake_late_o)
    else $error("wake overran bound");
  vec_range_a: assert property (wake_start_s |-> vec_valid_o
    && vec_addr_o[15:5] == 11'h7FF && !vec_addr_o[0]) else $error("vector outside table");
endmodule

//--- verification/test_low_power_mode_clock_gating.sv
// Testbench: mode gating, wake-up and vector lookup of the power controller
`timescale 1ns/1ns
module test_low_power_mode_clock_gating;
  logic        core_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        dto_used, aux_hf, raise, cpu_run, main_en, sub_en, aux_en, dcgen_en, xtal_en;
  logic        aux_hf_o, waking, late, vec_valid;
  logic [2:0]  sw_mode, mode_sel, mode;
  logic [3:0]  vec, irq_vec;
  logic        irq_pend;
  logic [15:0] vec_addr;
  logic [5:0]  gates;    // xtal dcgen aux sub main cpu
  int          n_fail = 0, n_checks = 0, seed = 32297, served, n, v, k = 0;
  logic [31:0] r;
  assign gates = {xtal_en, dcgen_en, aux_en, sub_en, main_en, cpu_run};
  always #50 core_clk_i = ~core_clk_i;
  lpc_power_ctrl lpc_power_ctrl_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .mode_sel_i(mode_sel), .irq_pend_i(irq_pend), .irq_vec_i(irq_vec), .dto_used_i(dto_used),
    .aux_src_hf_i(aux_hf), .cpu_run_o(cpu_run), .main_clk_en_o(main_en),
    .peripheral_subclock_en_o(sub_en), .aux_clk_en_o(aux_en), .aux_src_hf_o(aux_hf_o),
    .dto_dcgen_en_o(dcgen_en), .xtal_en_o(xtal_en), .mode_o(mode), .waking_o(waking),
    .wake_late_o(late), .vec_addr_o(vec_addr), .vec_valid_o(vec_valid));
  lpc_cpu_model lpc_cpu_model_i (.clk_i(core_clk_i), .cpu_run_i(cpu_run), .sw_mode_i(sw_mode),
    .raise_i(raise), .vec_i(vec), .mode_sel_o(mode_sel), .irq_pend_o(irq_pend),
    .irq_vec_o(irq_vec), .served_o(served));
  // Expected gates per mode code; level one keeps dc-generator only if used
  function automatic int exp_gates(int m, int dto);
    case (m)
      1: return 6'h3C;
      2: return dto ? 6'h3C : 6'h2C;
      3: return 6'h38;
      4: return 6'h28;
      5: return 6'h00;
      default: return 6'h3F;
    endcase
  endfunction
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Inputs move 10 ns after the edge, clear of sampling
  task automatic step(int c);
    repeat (c) @(posedge core_clk_i);
    #10;
  endtask
  task automatic check(input logic [15:0] got, input int exp, input string what);
    n_checks++;
    if (got !== 16'(exp)) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait on waking (0) or processor run (1); running out fails the run
  task automatic wait_for(input bit for_run, input int lim);
    n = 0;
    while ((for_run ? cpu_run : waking) !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    if ((for_run ? cpu_run : waking) !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  initial begin
    sw_mode = 3'h0; raise = 1'b0; vec = 4'h0; dto_used = 1'b1; aux_hf = 1'b0;
    step(3);
    check({10'h000, gates}, 6'h3F, "reset gates");
    check({13'h0000, mode}, 0, "reset mode");
    check(vec_addr, 16'hFFFE, "reset vector");
    step(3);
    nrst_i = 1'b1;
    step(4);
    // Every mode code, with a wake and re-sleep for each sleep level
    for (int m = 1; m < 8; m++) begin
      r = $random(seed);
      dto_used = r[4];
      aux_hf = r[5];
      v = int'(r[3:0]) % 15;
      step(2);
      sw_mode = 3'(m);
      step(5);
      check({10'h000, gates}, exp_gates(m, r[4]), "gates");
      check({15'h0000, aux_hf_o}, r[5], "aux source");
      check({13'h0000, mode}, (m > 5) ? 0 : m, "mode");
      if (m < 6) begin
        vec = 4'(v);
        raise = 1'b1;
        step(1);
        raise = 1'b0;
        wait_for(1'b0, 20);
        check(vec_addr, 16'hFFE0 + 2 * v, "vector");
        check({10'h000, gates}, 6'h38, "wake gates");
        wait_for(1'b1, 80);
        check({15'h0000, n <= 60}, 1, "wake time");
        k++;
        step(20);
        check(16'(served), k, "handler ran");
        check({10'h000, gates}, exp_gates(m, r[4]), "re-sleep");
      end
      sw_mode = 3'h0;
      // Leaving a sleep level runs a full oscillator settle first
      step(lpc_pkg::OSC_SETTLE_CYC + 5);
      check({10'h000, gates}, 6'h3F, "active");
    end
    end_sim();
  end
endmodule
bind lpc_power_ctrl lpc_power_ctrl_checker lpc_power_ctrl_checker_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .irq_pend_i(irq_pend_i), .cpu_run_o(cpu_run_o),
  .main_clk_en_o(main_clk_en_o), .peripheral_subclock_en_o(peripheral_subclock_en_o),
  .aux_clk_en_o(aux_clk_en_o), .dto_dcgen_en_o(dto_dcgen_en_o), .xtal_en_o(xtal_en_o),
  .waking_o(waking_o), .wake_late_o(wake_late_o), .vec_addr_o(vec_addr_o),
  .vec_valid_o(vec_valid_o));
